// file: hw/cies_top.sv
// Operation
// R01: five-bit field reports last matched filter number
// R02: fifo interrupt code equals the fifo index
// R03: codes for none, general error, wake-up
// R04: codes for receive overflow, address error
// R05: codes for timestamp, mode change, invalid message
// R06: bus bandwidth error reports code 1000101
// R07: code read-only, never in reserved ranges
// R08: only enabled sources change the code
// R09: fixed priority picks one code among several
// R10: bus-off when transmit count reaches 256
// R11: transmitter passive while transmit count >= 128
// R12: receiver passive while receive count >= 128
// R13: transmitter warning while count in 96..127
// R14: receiver warning while count in 96..127
// R15: combined warning when either side warns
// R16: error counts in bits 15:8 and 7:0
// R17: one pending bit per fifo, enabled only
// R18: unimplemented upper bits read as zero
`include "cies_map.svh"
`default_nettype none
module cies_top
  import cies_pkg::*;
(
  input wire logic clk, // 10 mhz clock
  input wire logic nrst, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high for write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic [31:0] fifo_events, // raw fifo interrupt levels
  input wire logic [7:0] sys_events, // one-cycle event pulses, see cies_evt_type
  input wire logic filter_hit_valid, // pulse: a filter matched
  input wire logic [4:0] filter_hit_num, // number of the matching filter
  input wire cies_err_in_type err_in, // error counter pulses
  output logic irq // level interrupt
);
  cies_state_type state;
  cies_state_type next_state;
  cies_err_type err;
  logic wr_en;
  logic rd_setup;
  logic [7:0] evt_clear;
  logic [7:0] evt_live;
  logic [31:0] code_word;
  logic [31:0] errcnt_word;
  logic [31:0] read_word;
  logic addr_ok;

  // counters and error states live in their own module
  cies_err_state u_err (
    .clk(clk),
    .nrst(nrst),
    .err_in(err_in),
    .err(err)
  );

  // one code out of all enabled pending sources; the lowest code wins,
  // so fifo 0 goes first and an invalid message goes last
  function automatic logic [6:0] pick_code(input logic [31:0] fifos, input logic [7:0] evts);
    logic [6:0] code;
    code = `CIES_CODE_NONE; // R03
    for (int i = 7; i >= 0; i--) begin
      if (evts[i]) begin
        code = `CIES_CODE_EVT_BASE + 7'(i); // R04 R05 R06
      end
    end
    for (int i = 31; i >= 0; i--) begin
      if (fifos[i]) begin
        code = 7'(i); // R02
      end
    end
    return code; // R09
  endfunction

  // register decode, shared by read and write
  function automatic logic is_mapped(input logic [7:0] addr);
    return addr == `CIES_OFF_CODE || addr == `CIES_OFF_ERRCNT || addr == `CIES_OFF_FIFO_PEND ||
      addr == `CIES_OFF_EVT_STATUS || addr == `CIES_OFF_EVT_CLEAR || addr == `CIES_OFF_EVT_ENABLE ||
      addr == `CIES_OFF_FIFO_ENABLE;
  endfunction

  // bus strobes: write lands in the access phase, read data is prepared in setup
  assign wr_en = psel & penable & pwrite & state.pready;
  assign rd_setup = psel & ~penable;
  assign addr_ok = is_mapped(paddr);
  assign evt_clear = (wr_en && paddr == `CIES_OFF_EVT_CLEAR) ? pwdata[7:0] : `CIES_RST_ZERO8;

  // readable words; unimplemented bits stay zero
  assign code_word = {19'h0, state.matched_filter_number, 1'b0, state.interrupt_source_code}; // R01 R18
  assign errcnt_word = {10'h000, err.transmitter_bus_off, err.transmitter_error_passive,
    err.receiver_error_passive, err.transmitter_warning, err.receiver_warning,
    err.combined_warning, (err.tec[8] ? 8'hff : err.tec[7:0]), err.rec}; // R16 R18

  // read mux; the clear register is write-only and reads as zero
  always_comb begin
    case (paddr)
      `CIES_OFF_CODE: read_word = code_word;
      `CIES_OFF_ERRCNT: read_word = errcnt_word;
      `CIES_OFF_FIFO_PEND: read_word = state.fifo_pending_bits;
      `CIES_OFF_EVT_STATUS: read_word = {24'h0, state.evt_status};
      `CIES_OFF_EVT_ENABLE: read_word = {24'h0, state.evt_enable};
      `CIES_OFF_FIFO_ENABLE: read_word = state.fifo_enable;
      default: read_word = `CIES_RST_ZERO32;
    endcase
  end

  // next state of the whole block
  always_comb begin
    next_state = state;
    // ready one cycle after setup gives a fixed zero-wait answer
    next_state.pready = rd_setup;
    next_state.pslverr = rd_setup & ~addr_ok;
    if (rd_setup && !pwrite) begin
      next_state.prdata = read_word;
    end else if (rd_setup) begin
      next_state.prdata = `CIES_RST_ZERO32;
    end
    if (wr_en && paddr == `CIES_OFF_EVT_ENABLE) begin
      next_state.evt_enable = pwdata[7:0];
    end
    if (wr_en && paddr == `CIES_OFF_FIFO_ENABLE) begin
      next_state.fifo_enable = pwdata;
    end
    // a new event beats a clear written in the same cycle
    next_state.evt_status = (state.evt_status & ~evt_clear) | sys_events;
    next_state.fifo_pending_bits = fifo_events & next_state.fifo_enable; // R17
    if (filter_hit_valid) begin
      next_state.matched_filter_number = filter_hit_num; // R01
    end
    // disabled sources are masked before the code is picked
    next_state.interrupt_source_code = pick_code(next_state.fifo_pending_bits,
      next_state.evt_status & next_state.evt_enable); // R08 R07
    next_state.irq = (|next_state.fifo_pending_bits) | (|(next_state.evt_status & next_state.evt_enable));
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= '0;
      state.interrupt_source_code <= `CIES_RST_CODE;
    end else begin
      state <= next_state;
    end
  end

  assign evt_live = state.evt_status & state.evt_enable;
  assign prdata = state.prdata;
  assign pready = state.pready;
  assign pslverr = state.pslverr;
  assign irq = state.irq;

  // checks on the reported code
  a_code_reserved: assert property (@(posedge clk) disable iff (!nrst) // R07
    state.interrupt_source_code <= 7'h1f ||
    (state.interrupt_source_code >= 7'h40 && state.interrupt_source_code <= 7'h48))
    else $error("interrupt code in a reserved range");

  a_code_idle: assert property (@(posedge clk) disable iff (!nrst) // R03
    (state.fifo_pending_bits == 32'h0 && evt_live == 8'h00) |-> state.interrupt_source_code == 7'h40)
    else $error("code not 1000000 with nothing pending");

  a_code_fifo: assert property (@(posedge clk) disable iff (!nrst) // R02
    (state.interrupt_source_code <= 7'h1f) |-> state.fifo_pending_bits[state.interrupt_source_code[4:0]])
    else $error("fifo code without its pending bit");

  a_fifo_first: assert property (@(posedge clk) disable iff (!nrst) // R09
    (state.fifo_pending_bits[0]) |-> state.interrupt_source_code == 7'h00)
    else $error("fifo 0 lost priority");

  a_evt_code: assert property (@(posedge clk) disable iff (!nrst) // R05
    (state.fifo_pending_bits == 32'h0 && evt_live == 8'h80) |-> state.interrupt_source_code == 7'h48)
    else $error("invalid message code wrong");

  a_bandwidth_code: assert property (@(posedge clk) disable iff (!nrst) // R06
    (state.fifo_pending_bits == 32'h0 && evt_live == 8'h10) |-> state.interrupt_source_code == 7'h45)
    else $error("bandwidth code wrong");

  a_disabled_quiet: assert property (@(posedge clk) disable iff (!nrst) // R08
    (state.fifo_pending_bits == 32'h0 && evt_live == 8'h00 && state.evt_status != 8'h00)
    |-> state.interrupt_source_code == 7'h40)
    else $error("disabled source changed the code");

  a_overflow_code: assert property (@(posedge clk) disable iff (!nrst) // R04
    (state.fifo_pending_bits == 32'h0 && evt_live == 8'h0c) |-> state.interrupt_source_code == 7'h43)
    else $error("overflow code wrong");

  // an event code is only legal while its own enabled status bit stands
  a_event_live: assert property (@(posedge clk) disable iff (!nrst) // R08
    (state.interrupt_source_code >= 7'h41 && state.interrupt_source_code <= 7'h48)
    |-> evt_live[state.interrupt_source_code[2:0] - 3'h1])
    else $error("event code without an enabled event");

  a_fifo_before_evt: assert property (@(posedge clk) disable iff (!nrst) // R09
    (state.interrupt_source_code >= 7'h40)
    |-> state.fifo_pending_bits == 32'h0)
    else $error("event code while a fifo is pending");

  a_error_code: assert property (@(posedge clk) disable iff (!nrst) // R03
    (state.fifo_pending_bits == 32'h0 && evt_live[0])
    |-> state.interrupt_source_code == 7'h41)
    else $error("general error code wrong");

  a_wake_code: assert property (@(posedge clk) disable iff (!nrst) // R03
    (state.fifo_pending_bits == 32'h0 && evt_live == 8'h02)
    |-> state.interrupt_source_code == 7'h42)
    else $error("wake-up code wrong");

  a_addr_code: assert property (@(posedge clk) disable iff (!nrst) // R04
    (state.fifo_pending_bits == 32'h0 && evt_live == 8'h08)
    |-> state.interrupt_source_code == 7'h44)
    else $error("address error code wrong");

  a_stamp_code: assert property (@(posedge clk) disable iff (!nrst) // R05
    (state.fifo_pending_bits == 32'h0 && evt_live == 8'h20)
    |-> state.interrupt_source_code == 7'h46)
    else $error("timestamp code wrong");

  a_mode_code: assert property (@(posedge clk) disable iff (!nrst) // R05
    (state.fifo_pending_bits == 32'h0 && evt_live == 8'h40)
    |-> state.interrupt_source_code == 7'h47)
    else $error("mode change code wrong");

  a_filter_field: assert property (@(posedge clk) disable iff (!nrst) // R01
    (psel && !penable && !pwrite && paddr == 8'h00)
    |=> (prdata[12:8] == $past(state.matched_filter_number) && prdata[7] == 1'b0))
    else $error("filter field misplaced");

  // checks on status, pending bits and the bus
  a_event_sticky: assert property (@(posedge clk) disable iff (!nrst)
    sys_events[1] |=> state.evt_status[1] ##1 (state.evt_status[1] || $past(evt_clear[1])))
    else $error("event flag lost");

  a_fifo_pending: assert property (@(posedge clk) disable iff (!nrst) // R17
    (fifo_events[5] && state.fifo_enable[5] && !wr_en) |=> state.fifo_pending_bits[5])
    else $error("enabled fifo not pending");

  a_filter_hit: assert property (@(posedge clk) disable iff (!nrst) // R01
    filter_hit_valid |=> state.matched_filter_number == $past(filter_hit_num))
    else $error("filter number not captured");

  a_upper_zero: assert property (@(posedge clk) disable iff (!nrst) // R18
    (psel && !penable && !pwrite && (paddr == 8'h00 || paddr == 8'h04)) |=> prdata[31:22] == 10'h000)
    else $error("unimplemented bits not zero");

  a_errcnt_layout: assert property (@(posedge clk) disable iff (!nrst) // R16
    (psel && !penable && !pwrite && paddr == 8'h04 && !err.tec[8]) |=>
    prdata[15:0] == {$past(err.tec[7:0]), $past(err.rec)})
    else $error("error counts misplaced");

  a_ready_once: assert property (@(posedge clk) disable iff (!nrst)
    (psel && !penable) |=> pready ##1 (!pready || (psel && !penable && $past(psel))))
    else $error("ready not a single cycle after setup");

  a_unmapped: assert property (@(posedge clk) disable iff (!nrst)
    (psel && !penable && paddr == 8'h20) |=> pslverr && pready)
    else $error("unmapped address accepted");

  a_irq_level: assert property (@(posedge clk) disable iff (!nrst)
    (evt_live != 8'h00) |-> irq)
    else $error("interrupt low with enabled status");

  // register writes land only in the access phase
  a_enable_write: assert property (@(posedge clk) disable iff (!nrst) // R08
    (psel && penable && pwrite && pready && paddr == 8'h14)
    |=> state.evt_enable == $past(pwdata[7:0]))
    else $error("event enable write lost");

  a_fifo_en_write: assert property (@(posedge clk) disable iff (!nrst) // R17
    (psel && penable && pwrite && pready && paddr == 8'h18)
    |=> state.fifo_enable == $past(pwdata))
    else $error("fifo enable write lost");

  a_code_readonly: assert property (@(posedge clk) disable iff (!nrst) // R07
    (psel && penable && pwrite && pready && paddr == 8'h00)
    |=> ($stable(state.evt_enable) && $stable(state.fifo_enable)))
    else $error("write to the code register changed state");

  a_clear_works: assert property (@(posedge clk) disable iff (!nrst)
    (psel && penable && pwrite && pready && paddr == 8'h10 && pwdata[0] && !sys_events[0])
    |=> !state.evt_status[0])
    else $error("status bit not cleared");

  a_set_wins: assert property (@(posedge clk) disable iff (!nrst)
    sys_events[0]
    |=> state.evt_status[0])
    else $error("event lost against a clear");

  // handshake outputs of the slave
  a_ready_in_access: assert property (@(posedge clk) disable iff (!nrst)
    pready
    |-> (psel && penable))
    else $error("ready outside an access phase");

  a_write_reads_zero: assert property (@(posedge clk) disable iff (!nrst)
    (psel && !penable && pwrite)
    |=> prdata == 32'h0000_0000)
    else $error("read data not zero on a write");

  a_unmapped_zero: assert property (@(posedge clk) disable iff (!nrst)
    (psel && !penable && !addr_ok)
    |=> (prdata == 32'h0000_0000 && pslverr))
    else $error("unmapped read not zero with error");

  a_mapped_no_error: assert property (@(posedge clk) disable iff (!nrst)
    (psel && !penable && addr_ok)
    |=> !pslverr)
    else $error("error flagged on a mapped address");

  // interrupt line and fifo pending bits
  a_irq_fifo: assert property (@(posedge clk) disable iff (!nrst) // R17
    (state.fifo_pending_bits != 32'h0)
    |-> irq)
    else $error("interrupt low with a fifo pending");

  a_irq_quiet: assert property (@(posedge clk) disable iff (!nrst) // R08
    (state.fifo_pending_bits == 32'h0 && evt_live == 8'h00)
    |-> !irq)
    else $error("interrupt high with nothing enabled pending");

  a_pending_masked: assert property (@(posedge clk) disable iff (!nrst) // R17
    (state.fifo_pending_bits & ~state.fifo_enable)
    == 32'h0000_0000)
    else $error("disabled fifo shows pending");

  a_pending_drops: assert property (@(posedge clk) disable iff (!nrst) // R17
    !fifo_events[31]
    |=> !state.fifo_pending_bits[31])
    else $error("fifo pending without its event");

  a_filter_hold: assert property (@(posedge clk) disable iff (!nrst) // R01
    !filter_hit_valid
    |=> $stable(state.matched_filter_number))
    else $error("filter number changed without a hit");

  c_fifo_code: cover property (@(posedge clk) disable iff (!nrst) state.interrupt_source_code == 7'h1f);
  c_clear_race: cover property (@(posedge clk) disable iff (!nrst) (evt_clear[0] && sys_events[0]));
  c_wake_code: cover property (@(posedge clk) disable iff (!nrst) state.interrupt_source_code == 7'h42);
  c_read_err: cover property (@(posedge clk) disable iff (!nrst) (pready && !pslverr && paddr == 8'h04));
endmodule
`default_nettype wire

// file: hw/cies_map.svh
`ifndef CIES_MAP_SVH
`define CIES_MAP_SVH
// register byte offsets on the apb bus
`define CIES_OFF_CODE 8'h00
`define CIES_OFF_ERRCNT 8'h04
`define CIES_OFF_FIFO_PEND 8'h08
`define CIES_OFF_EVT_STATUS 8'h0c
`define CIES_OFF_EVT_CLEAR 8'h10
`define CIES_OFF_EVT_ENABLE 8'h14
`define CIES_OFF_FIFO_ENABLE 8'h18
// field positions
`define CIES_POS_FILTER 8
`define CIES_POS_TEC 8
`define CIES_POS_ERR_FLAGS 16
// interrupt source codes
`define CIES_CODE_NONE 7'h40
`define CIES_CODE_EVT_BASE 7'h41
`define CIES_CODE_FIFO_LAST 7'h1f
`define CIES_CODE_EVT_LAST 7'h48
// error state thresholds and steps
`define CIES_TEC_BUS_OFF 9'h100
`define CIES_ERR_PASSIVE 9'h080
`define CIES_ERR_WARN 9'h060
`define CIES_REC_MAX 9'h0ff
`define CIES_TEC_STEP 9'h008
`define CIES_REC_STEP 9'h001
// reset values
`define CIES_RST_CODE 7'h40
`define CIES_RST_ZERO32 32'h0000_0000
`define CIES_RST_ZERO8 8'h00
`endif

// file: hw/cies_pkg.sv
`default_nettype none
package cies_pkg;
  // event order in the status, clear and enable registers
  typedef enum logic [2:0] {
    cies_evt_error = 3'b000,
    cies_evt_wakeup = 3'b001,
    cies_evt_rx_overflow = 3'b010,
    cies_evt_addr_error = 3'b011,
    cies_evt_bandwidth = 3'b100,
    cies_evt_timestamp = 3'b101,
    cies_evt_mode_change = 3'b110,
    cies_evt_invalid_msg = 3'b111
  } cies_evt_type;

  // error counter pulses from the protocol engine
  typedef struct packed {
    logic tx_error;
    logic tx_success;
    logic rx_error;
    logic rx_success;
    logic recover;
  } cies_err_in_type;

  // error counters and the states derived from them
  typedef struct packed {
    logic [8:0] tec;
    logic [7:0] rec;
    logic transmitter_bus_off;
    logic transmitter_error_passive;
    logic receiver_error_passive;
    logic transmitter_warning;
    logic receiver_warning;
    logic combined_warning;
  } cies_err_type;

  // whole state of the top module
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [7:0] evt_status;
    logic [7:0] evt_enable;
    logic [31:0] fifo_enable;
    logic [31:0] fifo_pending_bits;
    logic [6:0] interrupt_source_code;
    logic [4:0] matched_filter_number;
    logic irq;
  } cies_state_type;
endpackage
`default_nettype wire

// file: hw/cies_err_state.sv
`include "cies_map.svh"
`default_nettype none
module cies_err_state
  import cies_pkg::*;
(
  input wire logic clk, // 10 mhz clock
  input wire logic nrst, // async reset, active low
  input wire cies_err_in_type err_in, // counter pulses
  output var cies_err_type err // counters and states
);
  cies_err_type state;
  cies_err_type next_state;
  logic [8:0] tec;
  logic [8:0] rec;

  // counters move first, flags follow the new counts in the same cycle
  always_comb begin
    next_state = state;
    tec = state.tec;
    rec = {1'b0, state.rec};
    if (err_in.recover) begin
      tec = 9'h000;
      rec = 9'h000;
    end else begin
      // bus-off holds the count at its ceiling until recovery
      if (err_in.tx_error) begin
        tec = (tec >= `CIES_TEC_BUS_OFF - `CIES_TEC_STEP) ? `CIES_TEC_BUS_OFF : tec + `CIES_TEC_STEP; // R10
      end else if (err_in.tx_success && tec != 9'h000 && tec < `CIES_TEC_BUS_OFF) begin
        tec = tec - 9'h001;
      end
      if (err_in.rx_error) begin
        rec = (rec >= `CIES_REC_MAX) ? `CIES_REC_MAX : rec + `CIES_REC_STEP;
      end else if (err_in.rx_success && rec != 9'h000) begin
        rec = rec - 9'h001;
      end
    end
    next_state.tec = tec;
    next_state.rec = rec[7:0];
    next_state.transmitter_bus_off = tec >= `CIES_TEC_BUS_OFF; // R10
    next_state.transmitter_error_passive = tec >= `CIES_ERR_PASSIVE; // R11
    next_state.receiver_error_passive = rec >= `CIES_ERR_PASSIVE; // R12
    next_state.transmitter_warning = tec >= `CIES_ERR_WARN && tec < `CIES_ERR_PASSIVE; // R13
    next_state.receiver_warning = rec >= `CIES_ERR_WARN && rec < `CIES_ERR_PASSIVE; // R14
    next_state.combined_warning = next_state.transmitter_warning | next_state.receiver_warning; // R15
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign err = state;

  a_bus_off_entry: assert property (@(posedge clk) disable iff (!nrst) // R10
    (err_in.tx_error && !err_in.recover && state.tec >= 9'h0f8) |=> state.transmitter_bus_off)
    else $error("bus-off not entered at count 256");
  a_tx_passive: assert property (@(posedge clk) disable iff (!nrst) // R11
    (err_in.tx_error && !err_in.recover && state.tec == 9'h078) |=> state.transmitter_error_passive)
    else $error("transmitter passive flag disagrees with count");
  a_rx_passive: assert property (@(posedge clk) disable iff (!nrst) // R12
    (err_in.rx_error && !err_in.recover && state.rec == 8'h7f) |=> state.receiver_error_passive)
    else $error("receiver passive not entered at 128");
  a_warn_window: assert property (@(posedge clk) disable iff (!nrst) // R13
    state.transmitter_warning |-> (state.tec >= 9'h060 && state.tec <= 9'h07f))
    else $error("transmitter warning outside 96..127");
  a_rx_warn_window: assert property (@(posedge clk) disable iff (!nrst) // R14
    (state.rec >= 8'h60 && state.rec <= 8'h7f) |-> state.receiver_warning)
    else $error("receiver warning missing in 96..127");
  a_any_warning: assert property (@(posedge clk) disable iff (!nrst) // R15
    state.combined_warning == ((state.tec >= 9'h060 && state.tec <= 9'h07f) ||
    (state.rec >= 8'h60 && state.rec <= 8'h7f)))
    else $error("combined warning wrong");
  c_bus_off: cover property (@(posedge clk) disable iff (!nrst) $rose(state.transmitter_bus_off));
endmodule
`default_nettype wire

// file: test/cies_bus_node.sv
`default_nettype none
module cies_bus_node
  import cies_pkg::*;
(
  input wire logic clk, // bench clock
  input wire logic nrst, // async reset, active low
  input wire logic start, // begin a run of pulses
  input wire logic [2:0] kind, // bit of cies_err_in_type to pulse
  input wire logic [8:0] count, // pulses in the run
  input wire logic [3:0] gap, // idle cycles between pulses, 0 is prompt
  output logic busy, // run in progress
  output var cies_err_in_type err_in // one-cycle pulses to the block
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] left;
  logic [3:0] wait_cnt;
  logic [2:0] sel;
  assign busy = start | (left != 9'h000);
  // each error seen on the wire is one pulse; a gap models a slow bus
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      left <= 9'h000;
      wait_cnt <= 4'h0;
      sel <= 3'h0;
      err_in <= '0;
    end else begin
      err_in <= '0;
      if (start) begin
        left <= count;
        sel <= kind;
        wait_cnt <= 4'h0;
      end else if (left != 9'h000) begin
        if (wait_cnt == 4'h0) begin
          err_in <= cies_err_in_type'(5'h01 << sel);
          left <= left - 9'h001;
          wait_cnt <= gap;
        end else begin
          wait_cnt <= wait_cnt - 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: test/cies_top_tb_top.sv
`include "cies_map.svh"
`default_nettype none
module cies_top_tb_top
  import cies_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, filter_hit_valid = 0, start = 0;
  logic [7:0] paddr = 8'h00, sys_events = 8'h00;
  logic [31:0] pwdata = 32'h0, fifo_events = 32'h0, prdata, rdata;
  logic [4:0] filter_hit_num = 5'h00;
  logic pready, pslverr, irq, rerr, busy;
  logic [2:0] kind = 3'h0;
  logic [8:0] count = 9'h000;
  logic [3:0] gap = 4'h0;
  cies_err_in_type err_in;
  int bad_count = 0, tests_run = 0, cycles = 0;
  always #50 clk = ~clk;
  cies_top i_cies_top(.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fifo_events(fifo_events), .sys_events(sys_events), .filter_hit_valid(filter_hit_valid),
    .filter_hit_num(filter_hit_num), .err_in(err_in), .irq(irq));
  cies_bus_node i_cies_bus_node(.clk(clk), .nrst(nrst), .start(start), .kind(kind), .count(count),
    .gap(gap), .busy(busy), .err_in(err_in));
  task summarize;
    $display("checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // a hung handshake must still reach the report
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      summarize();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; no latency assumed, waits for pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask
  task ev(input logic [7:0] e);
    @(posedge clk);
    sys_events <= e;
    @(posedge clk);
    sys_events <= 8'h00;
  endtask
  // reset values
  task t_reset;
    rd(`CIES_OFF_CODE, 32'h40);
    rd(`CIES_OFF_ERRCNT, 32'h0);
  endtask
  // every system event code in turn, raised and cleared
  task t_events;
    apb(1'b1, `CIES_OFF_EVT_ENABLE, 32'hff);
    for (int i = 0; i < 8; i++) begin
      ev(8'h01 << i);
      rd(`CIES_OFF_CODE, 32'h41 + i);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, `CIES_OFF_EVT_CLEAR, 32'h1 << i);
      rd(`CIES_OFF_CODE, 32'h40);
      chk({31'h0, irq}, 32'h0);
    end
  endtask
  // two sources at once, then a masked one
  task t_prio_mask;
    ev(8'h84);
    rd(`CIES_OFF_CODE, 32'h43);
    apb(1'b1, `CIES_OFF_EVT_CLEAR, 32'h84);
    apb(1'b1, `CIES_OFF_EVT_ENABLE, 32'hfe);
    rd(`CIES_OFF_EVT_ENABLE, 32'hfe);
    ev(8'h01);
    rd(`CIES_OFF_CODE, 32'h40);
    rd(`CIES_OFF_EVT_STATUS, 32'h01);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, `CIES_OFF_EVT_CLEAR, 32'h01);
  endtask
  // read-only and unmapped places
  task t_access;
    apb(1'b1, `CIES_OFF_CODE, 32'hffff_ffff);
    rd(`CIES_OFF_CODE, 32'h40);
    rd(8'h20, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    rd(`CIES_OFF_EVT_CLEAR, 32'h0);
  endtask
  // fifo 0 raised but not enabled must not win
  task t_fifo;
    apb(1'b1, `CIES_OFF_FIFO_ENABLE, 32'h8000_0020);
    rd(`CIES_OFF_FIFO_ENABLE, 32'h8000_0020);
    fifo_events <= 32'h8000_0021;
    rd(`CIES_OFF_FIFO_PEND, 32'h8000_0020);
    rd(`CIES_OFF_CODE, 32'h05);
    chk({31'h0, irq}, 32'h1);
    fifo_events <= 32'h8000_0000;
    rd(`CIES_OFF_CODE, 32'h1f);
    fifo_events <= 32'h0;
    rd(`CIES_OFF_FIFO_PEND, 32'h0);
  endtask
  task t_filter;
    filter_hit_num <= 5'h1f;
    filter_hit_valid <= 1'b1;
    @(posedge clk);
    filter_hit_valid <= 1'b0;
    filter_hit_num <= 5'h00;
    rd(`CIES_OFF_CODE, 32'h1f40);
  endtask
  // hand a run of error pulses to the partner and wait for it
  task errs(input logic [2:0] k, input logic [8:0] c, input logic [3:0] g);
    int n;
    n = 0;
    kind <= k;
    count <= c;
    gap <= g;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (2) @(posedge clk);
    while (busy === 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
  endtask
  // thresholds at their exact boundaries
  task t_errors;
    errs(3'd2, 9'd96, 4'd0);
    rd(`CIES_OFF_ERRCNT, 32'h0003_0060);
    errs(3'd2, 9'd32, 4'd3);
    rd(`CIES_OFF_ERRCNT, 32'h0008_0080);
    errs(3'd4, 9'd12, 4'd1);
    rd(`CIES_OFF_ERRCNT, 32'h000d_6080);
    errs(3'd4, 9'd4, 4'd0);
    rd(`CIES_OFF_ERRCNT, 32'h0018_8080);
    errs(3'd4, 9'd16, 4'd2);
    rd(`CIES_OFF_ERRCNT, 32'h0038_ff80);
    // success while bus-off is ignored, then one receive success, then recovery
    errs(3'd3, 9'd1, 4'd0);
    rd(`CIES_OFF_ERRCNT, 32'h0038_ff80);
    errs(3'd1, 9'd1, 4'd0);
    rd(`CIES_OFF_ERRCNT, 32'h0033_ff7f);
    errs(3'd0, 9'd1, 4'd0);
    rd(`CIES_OFF_ERRCNT, 32'h0);
  endtask
  // second reset in mid-run; filter number and enables must fall back
  task t_rerun;
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    rd(`CIES_OFF_FIFO_ENABLE, 32'h0);
    rd(`CIES_OFF_EVT_ENABLE, 32'h0);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_events();
    t_prio_mask();
    t_access();
    t_fifo();
    t_filter();
    t_rerun();
    t_errors();
    summarize();
  end
endmodule
`default_nettype wire
